// >>> verif/asc_host_model.sv
// Host processor model that issues whole-word register accesses to the bank.
`timescale 1ns/1ps
module asc_host_model
  import asc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] rd_data,
  output asc_req_t         req
);
  initial req = '0;

  // caller-chosen reserved values
  // Requests are launched at the falling edge so the bank samples a settled word.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge sys_clk);
    req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
    @(negedge sys_clk);
    // Idle bus carries inverted leftovers so nothing relies on stale values.
    req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~v};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(negedge sys_clk);
    req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge sys_clk);
    // Read data stands for one cycle only, so it is taken before the strobe drops.
    v = rd_data;
    req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 16'hFFFF};
  endtask : rd
endmodule : asc_host_model

// >>> verif/tb.sv
// Self-checking testbench for the slot configuration bank.
`timescale 1ns/1ps
module tb;
  import asc_pkg::*;
  localparam int unsigned CYC = 3;
  logic        sys_clk;
  logic        rstn;
  logic        slot_b_active;
  logic [4:0]  second_window_fine_delay;
  logic [5:0]  ext_gain_ch234;
  asc_req_t    req;
  logic [15:0] rd_data;
  logic        rd_valid;
  asc_cfg_t    cfg;
  int          miscompares;
  int          checks_done;
  logic [15:0] d;

  asc_slot_cfg #(.CYC_PER_US(CYC)) asc_slot_cfg_i (
    .sys_clk(sys_clk), .rstn(rstn), .req(req), .slot_b_active(slot_b_active),
    .second_window_fine_delay(second_window_fine_delay), .ext_gain_ch234(ext_gain_ch234),
    .rd_data(rd_data), .rd_valid(rd_valid), .cfg(cfg));
  asc_host_model asc_host_model_i (.sys_clk(sys_clk), .rd_data(rd_data), .req(req));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    asc_host_model_i.rd(a, d);
    chk("rd_data", e, d);
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
    @(negedge sys_clk);
    chk("rd_valid_end", 16'h0000, {15'h0000, rd_valid});
    chk("rd_data_end", 16'h0000, rd_data);
  endtask : rdchk

  // Decoded settings trail a write by two edges.
  task automatic wrs(input logic [7:0] a, input logic [15:0] v);
    asc_host_model_i.wr(a, v);
    repeat (2) @(negedge sys_clk);
  endtask : wrs

  task automatic t_reset;
    rdchk(8'h39, 16'h22FC);
    rdchk(8'h42, 16'h1C38);
    rdchk(8'h58, 16'h0000);
    rdchk(8'h5A, 16'h0000);
    chk("win_width", 16'h0004, 16'(cfg.win_width));
    chk("win_cyc", 16'(4 * CYC), 16'(cfg.win_width_cyc));
    chk("win_coarse", 16'h0017, 16'(cfg.win_coarse));
    chk("win_fine", 16'h001C, 16'(cfg.win_fine));
    chk("bias_sel", 16'h0003, 16'(cfg.bias_sel));
    chk("full_chain", 16'h0001, 16'(cfg.full_chain));
    chk("mode_byte", 16'h001C, 16'(cfg.mode_byte));
    chk("mismatch", 16'h0000, 16'(cfg.mode_mismatch));
    chk("second_dig", 16'h0000, 16'(cfg.second_dig_int));
    chk("gapped", 16'h0000, 16'(cfg.gapped));
  endtask : t_reset

  task automatic t_mode;
    wrs(8'h58, 16'h3000);
    chk("first_dig", 16'h0001, 16'(cfg.first_dig_int));
    chk("second_dig", 16'h0001, 16'(cfg.second_dig_int));
    chk("int_buf", 16'h0001, 16'(cfg.int_as_buffer));
    chk("mismatch", 16'h0001, 16'(cfg.mode_mismatch));
    chk("full_chain", 16'h0000, 16'(cfg.full_chain));
    wrs(8'h42, 16'h1D34);
    chk("mode_byte", 16'h001D, 16'(cfg.mode_byte));
    chk("mismatch", 16'h0000, 16'(cfg.mode_mismatch));
    wrs(8'h58, 16'h2000);
    chk("first_dig", 16'h0000, 16'(cfg.first_dig_int));
    chk("second_dig", 16'h0001, 16'(cfg.second_dig_int));
    chk("int_buf", 16'h0000, 16'(cfg.int_as_buffer));
    chk("mismatch", 16'h0001, 16'(cfg.mode_mismatch));
    chk("full_chain", 16'h0000, 16'(cfg.full_chain));
    wrs(8'h42, 16'h1C34);
    chk("full_chain", 16'h0001, 16'(cfg.full_chain));
    chk("mismatch", 16'h0000, 16'(cfg.mode_mismatch));
  endtask : t_mode

  task automatic t_opts;
    wrs(8'h5A, 16'h00E0);
    chk("gapped", 16'h0001, 16'(cfg.gapped));
    chk("gap_us", 16'h001C, 16'(cfg.gap_us));
    chk("pair_a", 16'h0001, 16'(cfg.first_pair_single));
    chk("pair_b", 16'h0001, 16'(cfg.second_pair_single));
    slot_b_active = 1'b1;
    second_window_fine_delay = 5'h0B;
    repeat (2) @(negedge sys_clk);
    chk("gap_us_b", 16'h000B, 16'(cfg.gap_us));
    wrs(8'h5A, 16'h0040);
    chk("gapped", 16'h0000, 16'(cfg.gapped));
    chk("gap_us", 16'h0000, 16'(cfg.gap_us));
    chk("pair_b", 16'h0001, 16'(cfg.second_pair_single));
    chk("pair_a", 16'h0000, 16'(cfg.first_pair_single));
    slot_b_active = 1'b0;
  endtask : t_opts

  task automatic t_gain;
    ext_gain_ch234 = 6'h2D;
    wrs(8'h42, 16'h1C76);
    chk("indiv", 16'h0001, 16'(cfg.indiv_gain));
    chk("ch_gain", 16'h00B6, 16'(cfg.ch_gain));
    chk("ch1_gain", 16'h0002, 16'(cfg.ch_gain[1:0]));
    wrs(8'h42, 16'h1C06);
    chk("indiv", 16'h0000, 16'(cfg.indiv_gain));
    chk("ch_gain", 16'h00AA, 16'(cfg.ch_gain));
    chk("bias_sel", 16'h0000, 16'(cfg.bias_sel));
    chk("int_buf", 16'h0000, 16'(cfg.int_as_buffer));
    wrs(8'h42, 16'h1CB5);
    chk("int_buf", 16'h0001, 16'(cfg.int_as_buffer));
    chk("ch_gain", 16'h0055, 16'(cfg.ch_gain));
  endtask : t_gain

  task automatic t_map;
    asc_host_model_i.wr(8'h40, 16'hFFFF);
    rdchk(8'h40, 16'h0000);
    rdchk(8'h5A, 16'h0040);
    asc_host_model_i.wr(8'h39, 16'hFFFF);
    rdchk(8'h39, 16'hFFFF);
    chk("win_fine", 16'h001F, 16'(cfg.win_fine));
  endtask : t_map

  task automatic t_rerst;
    rstn = 1'b0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    rdchk(8'h39, 16'h22FC);
    rdchk(8'h5A, 16'h0000);
    chk("first_dig", 16'h0000, 16'(cfg.first_dig_int));
    chk("second_dig", 16'h0000, 16'(cfg.second_dig_int));
    chk("win_fine", 16'h001C, 16'(cfg.win_fine));
    chk("ch_gain", 16'h0000, 16'(cfg.ch_gain));
  endtask : t_rerst

  task automatic close_out;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  initial begin
    rstn = 1'b0;
    slot_b_active = 1'b0;
    second_window_fine_delay = 5'h00;
    ext_gain_ch234 = 6'h00;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_reset();
    t_mode();
    t_opts();
    t_gain();
    t_map();
    t_rerst();
    close_out();
  end
endmodule : tb

// >>> verilog/asc_cfg_word.sv
// One sixteen-bit read-write configuration word with a reset value.
`timescale 1ns/1ps
module asc_cfg_word
  import asc_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        wr_en,
  input  wire logic [15:0] wdata,
  output logic      [15:0] q
);
  asc_word_t state_reg;
  asc_word_t state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_en) begin
      state_next.value = wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg.value <= RESET_VALUE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.value;
endmodule : asc_cfg_word

// >>> verilog/asc_pkg.sv
// Constants, field layouts and carrier types for the slot configuration bank.
// Functional notes
// - Second-slot select bit 13: 0 normal mode, 1 digital integration.
// - First-slot select bit 12: 0 normal mode, 1 digital integration.
// - Gapped bit 7 of options register clear: no gap between sample regions.
// - Gapped set: gap in microseconds is active slot's fine delay field.
// - Second-slot pair bit 6: 0 double pair, 1 single pair.
// - First-slot pair bit 5: 0 double pair, 1 single pair.
// - Window width bits 15:11, 1 us steps, resets to 4.
// - Coarse delay bits 10:5, 1 us steps, resets to 0x17.
// - Fine delay bits 4:0, 31.25 ns steps, resets to 0x1C.
// - Mode byte 0x1C normal, 0x1D integration; software must match selected mode.
// - Normal mode routes amplifier, filter, integrator, then converter in order.
// - Bit 7 makes integrator a buffer; forced whenever first-slot digital integration runs.
// - Per-channel gain set: channel 1 from bits 1:0, others from external word.
// - Bias select bits 5:4 picks one of four levels, resets to 3.
// - Gain bits 1:0 codes 200/100/50/25 kohm apply to all four channels.
// - With per-channel gain enabled the gain field sets channel 1 only.
// - Sixteen-bit read-write registers; reserved bits reset to zero except mode pair.
package asc_pkg;
  localparam int unsigned ASC_ADDR_W       = 8;
  localparam int unsigned ASC_DATA_W       = 16;
  localparam logic [7:0]  ASC_OFS_WINDOW   = 8'h39;
  localparam logic [7:0]  ASC_OFS_CHAIN    = 8'h42;
  localparam logic [7:0]  ASC_OFS_MODESEL  = 8'h58;
  localparam logic [7:0]  ASC_OFS_OPTIONS  = 8'h5A;
  localparam logic [15:0] ASC_RST_WINDOW   = 16'h22FC;
  localparam logic [15:0] ASC_RST_CHAIN    = 16'h1C38;
  localparam logic [15:0] ASC_RST_MODESEL  = 16'h0000;
  localparam logic [15:0] ASC_RST_OPTIONS  = 16'h0000;
  localparam int unsigned ASC_B_SECOND_SEL = 13;
  localparam int unsigned ASC_B_FIRST_SEL  = 12;
  localparam int unsigned ASC_B_GAPPED     = 7;
  localparam int unsigned ASC_B_SECOND_PR  = 6;
  localparam int unsigned ASC_B_FIRST_PR   = 5;
  localparam int unsigned ASC_B_INT_BUF    = 7;
  localparam int unsigned ASC_B_INDIV      = 6;
  localparam logic [7:0]  ASC_MODE_NORMAL  = 8'h1C;
  localparam logic [7:0]  ASC_MODE_DIGINT  = 8'h1D;
  localparam int unsigned ASC_CLK_NS       = 10;
  localparam int unsigned ASC_STEP_US_NS   = 1000;
  localparam int unsigned ASC_CYC_PER_US   = ASC_STEP_US_NS / ASC_CLK_NS;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } asc_req_t;

  typedef struct packed {
    logic [15:0] value;
  } asc_word_t;

  typedef struct packed {
    logic        first_dig_int;
    logic        second_dig_int;
    logic        gapped;
    logic [4:0]  gap_us;
    logic        first_pair_single;
    logic        second_pair_single;
    logic [4:0]  win_width;
    logic [5:0]  win_coarse;
    logic [4:0]  win_fine;
    logic [11:0] win_width_cyc;
    logic [7:0]  mode_byte;
    logic        mode_mismatch;
    logic        full_chain;
    logic        int_as_buffer;
    logic        indiv_gain;
    logic [1:0]  bias_sel;
    logic [7:0]  ch_gain;
  } asc_cfg_t;
endpackage : asc_pkg

// >>> verilog/asc_slot_cfg.sv
// Slot configuration register bank with decoded settings for the front end.
`timescale 1ns/1ps
module asc_slot_cfg
  import asc_pkg::*;
#(
  parameter int unsigned CYC_PER_US = ASC_CYC_PER_US
) (
  input  wire logic     sys_clk,
  input  wire logic     rstn,
  input  wire asc_req_t req,
  input  wire logic     slot_b_active,
  input  wire logic [4:0] second_window_fine_delay,
  input  wire logic [5:0] ext_gain_ch234,
  output logic [15:0]   rd_data,
  output logic          rd_valid,
  output asc_cfg_t      cfg
);
  // The width cycle count is twelve bits wide, which holds a full window only up to 132.
  if (CYC_PER_US == 0 || CYC_PER_US > 132) begin : g_bad_cyc_per_us
    $error("CYC_PER_US out of range");
  end

  typedef struct packed {
    asc_cfg_t    cfg;
    logic [15:0] rd_data;
    logic        rd_valid;
  } asc_state_t;

  asc_state_t  state_reg;
  asc_state_t  state_next;
  logic [15:0] w_window;
  logic [15:0] w_chain;
  logic [15:0] w_modesel;
  logic [15:0] w_options;
  logic        we_window;
  logic        we_chain;
  logic        we_modesel;
  logic        we_options;

  assign we_window  = req.wr_en && (req.addr == ASC_OFS_WINDOW);
  assign we_chain   = req.wr_en && (req.addr == ASC_OFS_CHAIN);
  assign we_modesel = req.wr_en && (req.addr == ASC_OFS_MODESEL);
  assign we_options = req.wr_en && (req.addr == ASC_OFS_OPTIONS);

  asc_cfg_word #(.RESET_VALUE(ASC_RST_WINDOW)) u_window (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr_en   (we_window),
    .wdata   (req.wdata),
    .q       (w_window)
  );

  asc_cfg_word #(.RESET_VALUE(ASC_RST_CHAIN)) u_chain (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr_en   (we_chain),
    .wdata   (req.wdata),
    .q       (w_chain)
  );

  asc_cfg_word #(.RESET_VALUE(ASC_RST_MODESEL)) u_modesel (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr_en   (we_modesel),
    .wdata   (req.wdata),
    .q       (w_modesel)
  );

  asc_cfg_word #(.RESET_VALUE(ASC_RST_OPTIONS)) u_options (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr_en   (we_options),
    .wdata   (req.wdata),
    .q       (w_options)
  );

  always_comb begin
    state_next = state_reg;
    state_next.cfg.second_dig_int     = w_modesel[ASC_B_SECOND_SEL];
    state_next.cfg.first_dig_int      = w_modesel[ASC_B_FIRST_SEL];
    state_next.cfg.gapped             = w_options[ASC_B_GAPPED];
    if (!w_options[ASC_B_GAPPED]) begin
      state_next.cfg.gap_us = 5'h00;
    end else if (slot_b_active) begin
      state_next.cfg.gap_us = second_window_fine_delay;
    end else begin
      state_next.cfg.gap_us = w_window[4:0];
    end
    state_next.cfg.second_pair_single = w_options[ASC_B_SECOND_PR];
    state_next.cfg.first_pair_single  = w_options[ASC_B_FIRST_PR];
    state_next.cfg.win_width          = w_window[15:11];
    state_next.cfg.win_width_cyc      = 12'(32'(w_window[15:11]) * CYC_PER_US);
    state_next.cfg.win_coarse         = w_window[10:5];
    state_next.cfg.win_fine           = w_window[4:0];
    state_next.cfg.mode_byte          = w_chain[15:8];
    state_next.cfg.mode_mismatch      = w_chain[15:8] != (w_modesel[ASC_B_FIRST_SEL]
                                        ? ASC_MODE_DIGINT : ASC_MODE_NORMAL);
    state_next.cfg.full_chain         = !w_modesel[ASC_B_FIRST_SEL]
                                        && (w_chain[15:8] == ASC_MODE_NORMAL);
    state_next.cfg.int_as_buffer      = w_chain[ASC_B_INT_BUF] | w_modesel[ASC_B_FIRST_SEL];
    state_next.cfg.indiv_gain         = w_chain[ASC_B_INDIV];
    state_next.cfg.bias_sel           = w_chain[5:4];
    if (w_chain[ASC_B_INDIV]) begin
      state_next.cfg.ch_gain = {ext_gain_ch234, w_chain[1:0]};
    end else begin
      state_next.cfg.ch_gain = {4{w_chain[1:0]}};
    end
    state_next.rd_valid = req.rd_en;
    state_next.rd_data  = 16'h0000;
    if (req.rd_en) begin
      unique case (req.addr)
        ASC_OFS_WINDOW:  state_next.rd_data = w_window;
        ASC_OFS_CHAIN:   state_next.rd_data = w_chain;
        ASC_OFS_MODESEL: state_next.rd_data = w_modesel;
        ASC_OFS_OPTIONS: state_next.rd_data = w_options;
        default:         state_next.rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data  = state_reg.rd_data;
  assign rd_valid = state_reg.rd_valid;
  assign cfg      = state_reg.cfg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Decoded outputs trail the words by one cycle, so checks look one edge back at the words.
  AST_SECOND_MODE: assert property (
    ##2 cfg.second_dig_int == $past(w_modesel[ASC_B_SECOND_SEL], 1))
    else $error("second slot mode wrong");
  AST_FIRST_MODE: assert property (
    we_modesel ##1 1'b1 |=> cfg.first_dig_int == $past(req.wdata[ASC_B_FIRST_SEL], 2))
    else $error("first slot mode does not follow write");
  AST_NO_GAP: assert property (
    !w_options[ASC_B_GAPPED] |=> cfg.gap_us == 5'h00)
    else $error("gap present while gapped mode off");
  AST_GAP_SRC: assert property (
    w_options[ASC_B_GAPPED] && !slot_b_active |=> cfg.gap_us == $past(w_window[4:0]))
    else $error("gap not taken from first fine delay");
  AST_PAIRS: assert property (
    1'b1 |=> cfg.second_pair_single == $past(w_options[ASC_B_SECOND_PR])
    && cfg.first_pair_single == $past(w_options[ASC_B_FIRST_PR]))
    else $error("pair select mismatch");
  AST_WIDTH_CYC: assert property (
    1'b1 |=> cfg.win_width_cyc == 12'(32'(cfg.win_width) * CYC_PER_US))
    else $error("window width cycle count wrong");
  AST_BUFFER_FORCED: assert property (
    cfg.first_dig_int |-> cfg.int_as_buffer)
    else $error("integrator not buffered in digital integration");
  AST_CHAIN: assert property (
    cfg.full_chain |-> !cfg.first_dig_int && cfg.mode_byte == ASC_MODE_NORMAL)
    else $error("full chain in wrong mode");
  AST_COMMON_GAIN: assert property (
    !cfg.indiv_gain && $stable(w_chain) |=> cfg.ch_gain == {4{$past(w_chain[1:0])}})
    else $error("common gain not applied to all channels");
  AST_READ: assert property (
    req.rd_en && req.addr == ASC_OFS_WINDOW && !we_window |=> rd_valid
    && rd_data == $past(w_window))
    else $error("read back of window word wrong");

  // Each decoded field must be the registered copy of its word bits or external input, or follow from other fields.
  AST_SECOND_FOLLOWS: assert property (
    we_modesel ##1 1'b1 |=> cfg.second_dig_int == $past(req.wdata[ASC_B_SECOND_SEL], 2))
    else $error("second slot mode does not follow write");
  AST_GAPPED_FLAG: assert property (
    1'b1 |=> cfg.gapped == $past(w_options[ASC_B_GAPPED]))
    else $error("gapped flag does not follow options word");
  AST_GAP_SRC_B: assert property (
    w_options[ASC_B_GAPPED] && slot_b_active
    |=> cfg.gap_us == $past(second_window_fine_delay))
    else $error("gap not taken from second fine delay");
  AST_PAIR_SECOND_WRITE: assert property (
    we_options ##1 1'b1 |=> cfg.second_pair_single == $past(req.wdata[ASC_B_SECOND_PR], 2))
    else $error("second pair select does not follow write");
  AST_PAIR_FIRST_WRITE: assert property (
    we_options ##1 1'b1 |=> cfg.first_pair_single == $past(req.wdata[ASC_B_FIRST_PR], 2))
    else $error("first pair select does not follow write");
  AST_WIDTH_FIELD: assert property (
    1'b1 |=> cfg.win_width == $past(w_window[15:11]))
    else $error("window width field wrong");
  AST_WIDTH_CYC_VALUE: assert property (
    1'b1 |=> cfg.win_width_cyc == 12'(32'($past(w_window[15:11])) * CYC_PER_US))
    else $error("window width cycles do not follow window word");
  AST_COARSE_FIELD: assert property (
    1'b1 |=> cfg.win_coarse == $past(w_window[10:5]))
    else $error("coarse delay field wrong");
  AST_FINE_FIELD: assert property (
    1'b1 |=> cfg.win_fine == $past(w_window[4:0]))
    else $error("fine delay field wrong");
  AST_MODE_BYTE: assert property (
    1'b1 |=> cfg.mode_byte == $past(w_chain[15:8]))
    else $error("mode byte does not follow chain word");
  AST_MISMATCH_DIG: assert property (
    cfg.first_dig_int |-> cfg.mode_mismatch == (cfg.mode_byte != ASC_MODE_DIGINT))
    else $error("mode mismatch flag wrong in digital integration");
  AST_MISMATCH_NORM: assert property (
    $past(rstn) && !cfg.first_dig_int
    |-> cfg.mode_mismatch == (cfg.mode_byte != ASC_MODE_NORMAL))
    else $error("mode mismatch flag wrong in normal mode");
  AST_CHAIN_NORMAL: assert property (
    !cfg.first_dig_int && cfg.mode_byte == ASC_MODE_NORMAL |-> cfg.full_chain)
    else $error("full chain not routed in normal mode");
  AST_BUFFER_BIT: assert property (
    1'b1 |=> cfg.int_as_buffer == ($past(w_chain[ASC_B_INT_BUF])
    || $past(w_modesel[ASC_B_FIRST_SEL])))
    else $error("integrator buffer select wrong");
  AST_INDIV_FLAG: assert property (
    1'b1 |=> cfg.indiv_gain == $past(w_chain[ASC_B_INDIV]))
    else $error("per-channel gain enable wrong");
  AST_INDIV_GAIN: assert property (
    w_chain[ASC_B_INDIV] |=> cfg.ch_gain[7:2] == $past(ext_gain_ch234))
    else $error("channels two to four not taken from external gains");
  AST_CH1_GAIN: assert property (
    1'b1 |=> cfg.ch_gain[1:0] == $past(w_chain[1:0]))
    else $error("channel one gain not taken from gain field");
  AST_BIAS: assert property (
    1'b1 |=> cfg.bias_sel == $past(w_chain[5:4]))
    else $error("bias select does not follow chain word");

  // Words change only when written, and a write lands whole at its own edge.
  AST_WINDOW_WRITE: assert property (
    we_window |=> w_window == $past(req.wdata))
    else $error("window word write did not land");
  AST_CHAIN_WRITE: assert property (
    we_chain |=> w_chain == $past(req.wdata))
    else $error("chain word write did not land");
  AST_MODESEL_WRITE: assert property (
    we_modesel |=> w_modesel == $past(req.wdata))
    else $error("mode select word write did not land");
  AST_OPTIONS_WRITE: assert property (
    we_options |=> w_options == $past(req.wdata))
    else $error("options word write did not land");
  AST_WINDOW_HOLD: assert property (
    !we_window |=> $stable(w_window))
    else $error("window word changed without a write");
  AST_CHAIN_HOLD: assert property (
    !we_chain |=> $stable(w_chain))
    else $error("chain word changed without a write");
  AST_MODESEL_HOLD: assert property (
    !we_modesel |=> $stable(w_modesel))
    else $error("mode select word changed without a write");
  AST_OPTIONS_HOLD: assert property (
    !we_options |=> $stable(w_options))
    else $error("options word changed without a write");

  // Read data stands for one cycle and is zero otherwise, so a late sampler sees zero.
  AST_READ_CHAIN: assert property (
    req.rd_en && req.addr == ASC_OFS_CHAIN |=> rd_valid
    && rd_data == $past(w_chain))
    else $error("read back of chain word wrong");
  AST_READ_MODESEL: assert property (
    req.rd_en && req.addr == ASC_OFS_MODESEL |=> rd_valid
    && rd_data == $past(w_modesel))
    else $error("read back of mode select word wrong");
  AST_READ_OPTIONS: assert property (
    req.rd_en && req.addr == ASC_OFS_OPTIONS |=> rd_valid
    && rd_data == $past(w_options))
    else $error("read back of options word wrong");
  AST_UNMAPPED_READ: assert property (
    req.rd_en && req.addr != ASC_OFS_WINDOW && req.addr != ASC_OFS_CHAIN
    && req.addr != ASC_OFS_MODESEL && req.addr != ASC_OFS_OPTIONS
    |=> rd_valid && rd_data == 16'h0000)
    else $error("unmapped read did not return zero");
  AST_READ_PULSE: assert property (
    !req.rd_en |=> !rd_valid && rd_data == 16'h0000)
    else $error("read data stands without a read");

  // Reset is checked with the disable lifted, since the default one would hide it.
  AST_RESET_WORDS: assert property (
    disable iff (1'b0) !rstn |=> w_window == ASC_RST_WINDOW && w_chain == ASC_RST_CHAIN
    && w_modesel == ASC_RST_MODESEL && w_options == ASC_RST_OPTIONS)
    else $error("words not at reset values after reset");
  AST_CFG_RESET: assert property (
    disable iff (1'b0) !rstn |=> cfg == '0 && !rd_valid && rd_data == 16'h0000)
    else $error("outputs not cleared by reset");
endmodule : asc_slot_cfg
